// file: rtl/rx_clk_params.svh
`ifndef RX_CLK_PARAMS_SVH
`define RX_CLK_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define RXC_CTRL_OFF 12'h000
`define RXC_STAT_OFF 12'h004
`define RXC_CTRL_SRC_LSB 0
`define RXC_CTRL_SRC_MSB 1
`define RXC_CTRL_RATE_BIT 2
`define RXC_CTRL_MODE_LSB 3
`define RXC_CTRL_MODE_MSB 6
`define RXC_CTRL_RST 7'h01
`define RXC_CTRL_WIDTH 7
`define RXC_STAT_WIDTH 5

// ----------------------------------------
// operating mode numbers
// ----------------------------------------
`define RXC_MODE_INDEP0 4'h0
`define RXC_MODE_INDEP2 4'h2
`define RXC_MODE_DUAL3 4'h3
`define RXC_MODE_DUAL5 4'h5
`define RXC_MODE_QUAD6 4'h6
`define RXC_MODE_QUAD8 4'h8

`endif

// file: rtl/rx_clk_pkg.sv
package rx_clk_pkg;
    // three-level clock source select
    typedef enum logic [1:0] {
        SRC_REF = 2'h0,
        SRC_RECOV = 2'h1,
        SRC_BOND = 2'h2
    } src_mode_t;

    typedef enum logic [1:0] {
        BOND_NONE = 2'h0,
        BOND_DUAL = 2'h1,
        BOND_QUAD = 2'h2,
        BOND_INDEP = 2'h3
    } bond_kind_t;
endpackage

// file: rtl/sync_2ff.sv
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_level,
    output logic [WIDTH-1:0] sync_level
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_level <= '0;
        end
        else
        begin
            meta_q <= async_level;
            sync_level <= meta_q;
        end
    end
endmodule

// file: rtl/rx_output_clock_select.sv
// Behaviour
// - recovered-clock mode: each channel clock pair follows its own recovered clock
// - recovered clocks run continuously at character rate or half character rate
// - true and complement clock pins are driven together
// - reference mode: B and D float, A and C carry delayed reference copies
// - reference copies on A and C differ slightly in phase
// - reference mode with quad bonding: B and D true pins are master selects
// - bonded dual mode: A picks channel A/B, C picks channel C/D
// - bonded quad or independent mode: A and C carry one of four channels
// - reference mode ignores rate select and keeps reference frequency and duty
`include "rx_clk_params.svh"
module rx_output_clock_select
    import rx_clk_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NCH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic [NCH-1:0] rec_char_tick,
    input wire logic reference_clock,
    output logic rx_if_clk_a_p,
    output logic rx_if_clk_a_n,
    output logic rx_if_clk_a_oe,
    input wire logic rx_if_clk_b_or_sel0_p_level,
    output logic rx_if_clk_b_or_sel0_p,
    output logic rx_if_clk_b_or_sel0_n,
    output logic rx_if_clk_b_or_sel0_oe,
    output logic rx_if_clk_c_p,
    output logic rx_if_clk_c_n,
    output logic rx_if_clk_c_oe,
    input wire logic rx_if_clk_d_or_sel1_p_level,
    output logic rx_if_clk_d_or_sel1_p,
    output logic rx_if_clk_d_or_sel1_n,
    output logic rx_if_clk_d_or_sel1_oe,
    output logic [1:0] bond_master_sel
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic bond_kind_t bond_kind(input logic [3:0] m);
        case (m)
            `RXC_MODE_INDEP0, `RXC_MODE_INDEP2: bond_kind = BOND_INDEP;
            `RXC_MODE_DUAL3, `RXC_MODE_DUAL5: bond_kind = BOND_DUAL;
            `RXC_MODE_QUAD6, `RXC_MODE_QUAD8: bond_kind = BOND_QUAD;
            default: bond_kind = BOND_NONE;
        endcase
    endfunction

    // true when B/D true pins act as select inputs
    function automatic logic sel_pins_in(input src_mode_t s, input logic [3:0] m);
        sel_pins_in = (s == SRC_REF) ? (bond_kind(m) == BOND_QUAD)
                    : ((s == SRC_BOND) && (bond_kind(m) != BOND_NONE));
    endfunction

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    logic [`RXC_CTRL_WIDTH-1:0] ctrl_q;
    logic [`RXC_STAT_WIDTH-1:0] stat_s;
    logic access;
    logic hit_ctrl;
    logic hit_stat;
    assign access = psel && penable;
    assign hit_ctrl = (paddr == `RXC_CTRL_OFF);
    assign hit_stat = (paddr == `RXC_STAT_OFF);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pready <= 1'b0;
        else
            pready <= access && !pready;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (access && !pready)
        begin
            pslverr <= !(hit_ctrl || hit_stat);
            if (!pwrite && hit_ctrl)
                prdata <= {{(32-`RXC_CTRL_WIDTH){1'b0}}, ctrl_q};
            else if (!pwrite && hit_stat)
                prdata <= {{(32-`RXC_STAT_WIDTH){1'b0}}, stat_s};
            else
                prdata <= 32'h00000000;
        end
    end

    // write lands on the edge that samples pready high
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `RXC_CTRL_RST;
        else if (access && pready && pwrite && hit_ctrl)
            ctrl_q <= pwdata[`RXC_CTRL_WIDTH-1:0];
    end

    // ----------------------------------------
    // crossings into the link domain
    // ----------------------------------------
    logic link_rst_meta_q;
    logic link_rst_n_q;
    logic [`RXC_CTRL_WIDTH-1:0] ctrl_l;
    logic [1:0] sel_l;
    logic ref_l;
    src_mode_t src_l;
    logic rate_l;
    logic [3:0] mode_l;

    // async assert, synchronous release in link domain
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_rst_meta_q <= 1'b0;
            link_rst_n_q <= 1'b0;
        end
        else
        begin
            link_rst_meta_q <= 1'b1;
            link_rst_n_q <= link_rst_meta_q;
        end
    end

    // static selects, multi-bit sync is safe only because they do not move
    sync_2ff #(.WIDTH(`RXC_CTRL_WIDTH)) u_ctrl_sync (
        .clk(link_clk),
        .rst_n(link_rst_n_q),
        .async_level(ctrl_q),
        .sync_level(ctrl_l)
    );
    sync_2ff #(.WIDTH(3)) u_pin_sync (
        .clk(link_clk),
        .rst_n(link_rst_n_q),
        .async_level({rx_if_clk_d_or_sel1_p_level, rx_if_clk_b_or_sel0_p_level, reference_clock}),
        .sync_level({sel_l, ref_l})
    );

    assign src_l = src_mode_t'(ctrl_l[`RXC_CTRL_SRC_MSB:`RXC_CTRL_SRC_LSB]);
    assign rate_l = ctrl_l[`RXC_CTRL_RATE_BIT];
    assign mode_l = ctrl_l[`RXC_CTRL_MODE_MSB:`RXC_CTRL_MODE_LSB];

    // ----------------------------------------
    // per-channel recovered clock dividers
    // ----------------------------------------
    logic [NCH-1:0] char_q;
    logic [NCH-1:0] half_q;
    logic [NCH-1:0] ch_clk;

    // a tick marks each half period of the character clock
    always_ff @(posedge link_clk or negedge link_rst_n_q)
    begin
        if (!link_rst_n_q)
        begin
            char_q <= '0;
            half_q <= '0;
        end
        else
        begin
            char_q <= char_q ^ rec_char_tick;
            half_q <= half_q ^ (rec_char_tick & char_q);
        end
    end

    assign ch_clk = rate_l ? half_q : char_q;

    // ----------------------------------------
    // output clock selection
    // ----------------------------------------
    logic ref_dly_q;
    logic a_d;
    logic c_d;
    logic b_d;
    logic d_d;
    logic ac_en_d;
    logic bd_en_d;

    always_ff @(posedge link_clk or negedge link_rst_n_q)
    begin
        if (!link_rst_n_q)
            ref_dly_q <= 1'b0;
        else
            ref_dly_q <= ref_l;
    end

    always_comb
    begin
        a_d = ch_clk[0];
        c_d = ch_clk[2];
        b_d = ch_clk[1];
        d_d = ch_clk[3];
        ac_en_d = 1'b1;
        bd_en_d = 1'b1;
        case (src_l)
            SRC_REF:
            begin
                // rate select unused, copies keep reference duty
                a_d = ref_l;
                c_d = ref_dly_q;
                bd_en_d = 1'b0;
            end
            SRC_RECOV: bd_en_d = 1'b1;
            SRC_BOND:
            begin
                bd_en_d = !sel_pins_in(src_l, mode_l);
                case (bond_kind(mode_l))
                    BOND_DUAL:
                    begin
                        a_d = sel_l[0] ? ch_clk[1] : ch_clk[0];
                        c_d = sel_l[1] ? ch_clk[3] : ch_clk[2];
                    end
                    BOND_QUAD, BOND_INDEP:
                    begin
                        a_d = ch_clk[sel_l];
                        c_d = ch_clk[sel_l];
                    end
                    default: a_d = ch_clk[0];
                endcase
            end
            default:
            begin
                ac_en_d = 1'b0;
                bd_en_d = 1'b0;
            end
        endcase
    end

    // pins are registered so true and complement switch on one edge
    always_ff @(posedge link_clk or negedge link_rst_n_q)
    begin
        if (!link_rst_n_q)
        begin
            rx_if_clk_a_p <= 1'b0;
            rx_if_clk_a_n <= 1'b1;
            rx_if_clk_c_p <= 1'b0;
            rx_if_clk_c_n <= 1'b1;
            rx_if_clk_b_or_sel0_p <= 1'b0;
            rx_if_clk_b_or_sel0_n <= 1'b1;
            rx_if_clk_d_or_sel1_p <= 1'b0;
            rx_if_clk_d_or_sel1_n <= 1'b1;
        end
        else
        begin
            rx_if_clk_a_p <= a_d;
            rx_if_clk_a_n <= !a_d;
            rx_if_clk_c_p <= c_d;
            rx_if_clk_c_n <= !c_d;
            rx_if_clk_b_or_sel0_p <= b_d;
            rx_if_clk_b_or_sel0_n <= !b_d;
            rx_if_clk_d_or_sel1_p <= d_d;
            rx_if_clk_d_or_sel1_n <= !d_d;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n_q)
    begin
        if (!link_rst_n_q)
        begin
            rx_if_clk_a_oe <= 1'b0;
            rx_if_clk_c_oe <= 1'b0;
            rx_if_clk_b_or_sel0_oe <= 1'b0;
            rx_if_clk_d_or_sel1_oe <= 1'b0;
            bond_master_sel <= 2'h0;
        end
        else
        begin
            rx_if_clk_a_oe <= ac_en_d;
            rx_if_clk_c_oe <= ac_en_d;
            rx_if_clk_b_or_sel0_oe <= bd_en_d;
            rx_if_clk_d_or_sel1_oe <= bd_en_d;
            if ((src_l == SRC_REF) && (bond_kind(mode_l) == BOND_QUAD))
                bond_master_sel <= sel_l;
        end
    end

    // status back to the bus side: selects, pin role, source mode
    sync_2ff #(.WIDTH(`RXC_STAT_WIDTH)) u_stat_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .async_level({ctrl_l[`RXC_CTRL_SRC_MSB:`RXC_CTRL_SRC_LSB], sel_pins_in(src_l, mode_l), sel_l}),
        .sync_level(stat_s)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!link_rst_n_q);
    sequence s_ref_steady;
        (src_l == SRC_REF) [*3];
    endsequence
    sequence s_rec_steady;
        (src_l == SRC_RECOV) [*2];
    endsequence
    a_mid_follow_own: assert property (s_rec_steady |-> rx_if_clk_a_p == $past(ch_clk[0])
        && rx_if_clk_d_or_sel1_p == $past(ch_clk[3]))
        else $error("recovered mode clock does not follow own channel");
    a_char_rate_toggle: assert property ((src_l == SRC_RECOV) && !rate_l && rec_char_tick[0]
        ##1 (src_l == SRC_RECOV) && !rate_l |=> rx_if_clk_a_p != $past(rx_if_clk_a_p))
        else $error("character rate clock did not toggle on tick");
    a_true_compl: assert property (rx_if_clk_a_n == !rx_if_clk_a_p
        && rx_if_clk_c_n == !rx_if_clk_c_p && rx_if_clk_b_or_sel0_n == !rx_if_clk_b_or_sel0_p)
        else $error("complement clock not inverse of true clock");
    a_ref_bd_float: assert property ((src_l == SRC_REF) |=> !rx_if_clk_b_or_sel0_oe
        && !rx_if_clk_d_or_sel1_oe && rx_if_clk_a_oe)
        else $error("B or D driven in reference mode");
    a_ref_phase_skew: assert property (s_ref_steady |-> rx_if_clk_c_p == $past(rx_if_clk_a_p))
        else $error("reference copy on C not one cycle behind A");
    a_ref_ignore_rate: assert property ((src_l == SRC_REF) ##1 (src_l == SRC_REF)
        |-> rx_if_clk_a_p == $past(ref_l))
        else $error("reference copy on A not tracking reference");
    a_quad_master_sel: assert property ((src_l == SRC_REF) && (bond_kind(mode_l) == BOND_QUAD)
        |=> bond_master_sel == $past(sel_l))
        else $error("master channel select not captured");
    a_dual_pick: assert property ((src_l == SRC_BOND) && (bond_kind(mode_l) == BOND_DUAL)
        |=> rx_if_clk_c_p == $past(sel_l[1] ? ch_clk[3] : ch_clk[2]) && !rx_if_clk_d_or_sel1_oe)
        else $error("dual bonded clock C picks wrong channel");
    a_quad_pick: assert property ((src_l == SRC_BOND) && (bond_kind(mode_l) == BOND_QUAD)
        |=> rx_if_clk_a_p == $past(ch_clk[sel_l]) && rx_if_clk_c_p == rx_if_clk_a_p)
        else $error("quad bonded clock picks wrong channel");
endmodule

// file: verification/rx_host_model.sv
module rx_host_model (
    input wire logic [1:0] sel_drive,
    input wire logic b_p,
    input wire logic b_oe,
    input wire logic d_p,
    input wire logic d_oe,
    input wire logic a_p,
    input wire logic a_n,
    input wire logic half_rate,
    output logic b_wire,
    output logic d_wire,
    output int captures
);
    timeunit 1ns;
    timeprecision 100ps;

    int cap_p = 0;
    int cap_n = 0;

    // ----------------------------------------
    // shared clock/select pins
    // ----------------------------------------
    // straps only take the wire once the device lets go of it
    assign b_wire = b_oe ? b_p : sel_drive[0];
    assign d_wire = d_oe ? d_p : sel_drive[1];

    // ----------------------------------------
    // capture edges
    // ----------------------------------------
    always @(posedge a_p)
        cap_p <= cap_p + 1;
    // half rate: complement rising edge takes every other word
    always @(posedge a_n)
        if (half_rate)
            cap_n <= cap_n + 1;
    assign captures = cap_p + cap_n;
endmodule

// file: verification/rx_output_clock_select_test.sv
`include "rx_clk_params.svh"
module rx_output_clock_select_test
    import rx_clk_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] rec_char_tick = 4'h0;
    logic reference_clock = 1'b0;
    logic rx_if_clk_a_p, rx_if_clk_a_n, rx_if_clk_a_oe;
    logic rx_if_clk_b_or_sel0_p_level, rx_if_clk_b_or_sel0_p, rx_if_clk_b_or_sel0_n, rx_if_clk_b_or_sel0_oe;
    logic rx_if_clk_c_p, rx_if_clk_c_n, rx_if_clk_c_oe;
    logic rx_if_clk_d_or_sel1_p_level, rx_if_clk_d_or_sel1_p, rx_if_clk_d_or_sel1_n, rx_if_clk_d_or_sel1_oe;
    logic [1:0] bond_master_sel;
    logic [1:0] sel_drive = 2'h0;
    logic rx_rate = 1'b0;
    logic cnt_clr = 1'b1;
    logic [31:0] rd;
    logic err;
    logic [3:0] prev_p;
    int captures;
    int tog [4];
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    wire logic [3:0] pins_p = {rx_if_clk_d_or_sel1_p, rx_if_clk_c_p, rx_if_clk_b_or_sel0_p, rx_if_clk_a_p};
    wire logic [3:0] pins_n = {rx_if_clk_d_or_sel1_n, rx_if_clk_c_n, rx_if_clk_b_or_sel0_n, rx_if_clk_a_n};
    wire logic [3:0] pins_oe = {rx_if_clk_d_or_sel1_oe, rx_if_clk_c_oe, rx_if_clk_b_or_sel0_oe, rx_if_clk_a_oe};

    rx_output_clock_select u_dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link_clk, .rec_char_tick, .reference_clock, .rx_if_clk_a_p, .rx_if_clk_a_n,
        .rx_if_clk_a_oe, .rx_if_clk_b_or_sel0_p_level, .rx_if_clk_b_or_sel0_p, .rx_if_clk_b_or_sel0_n,
        .rx_if_clk_b_or_sel0_oe, .rx_if_clk_c_p, .rx_if_clk_c_n, .rx_if_clk_c_oe, .rx_if_clk_d_or_sel1_p_level,
        .rx_if_clk_d_or_sel1_p, .rx_if_clk_d_or_sel1_n, .rx_if_clk_d_or_sel1_oe, .bond_master_sel);

    rx_host_model u_host (.sel_drive, .b_p(rx_if_clk_b_or_sel0_p), .b_oe(rx_if_clk_b_or_sel0_oe),
        .d_p(rx_if_clk_d_or_sel1_p), .d_oe(rx_if_clk_d_or_sel1_oe), .a_p(rx_if_clk_a_p), .a_n(rx_if_clk_a_n),
        .half_rate(rx_rate), .b_wire(rx_if_clk_b_or_sel0_p_level), .d_wire(rx_if_clk_d_or_sel1_p_level),
        .captures);

    // ----------------------------------------
    // clocks, timeout, edge counters
    // ----------------------------------------
    always #5 clk_sys = ~clk_sys;
    // odd offset keeps link edges off the bus clock edges
    initial
    begin
        #3.3;
        forever #32 link_clk = ~link_clk;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            conclude();
        end
    end

    always @(negedge link_clk)
    begin
        for (int i = 0; i < 4; i++)
            tog[i] <= cnt_clr ? 0 : tog[i] + int'(pins_p[i] !== prev_p[i]);
        prev_p <= pins_p;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [1:0] src, input logic rate, input logic [3:0] mode);
        apb(1'b1, `RXC_CTRL_OFF, {25'h0, mode, rate, src});
        rx_rate = rate;
        repeat (8) @(posedge link_clk);
        cnt_clr = 1'b1;
        repeat (2) @(posedge link_clk);
        cnt_clr = 1'b0;
    endtask

    // channel i gets 2*(i+1) ticks, so every pin shows which channel feeds it
    task automatic run(input string what, input int src [4]);
        int c0;
        int e;
        c0 = captures;
        for (int k = 0; k < 8; k++)
        begin
            for (int i = 0; i < 4; i++)
                rec_char_tick[i] <= (k < 2 * i + 2);
            @(posedge link_clk);
            rec_char_tick <= 4'h0;
            @(posedge link_clk);
        end
        repeat (6) @(posedge link_clk);
        @(negedge link_clk);
        for (int i = 0; i < 4; i++)
        begin
            check({what, " enable"}, src[i] >= 0, pins_oe[i]);
            e = rx_rate ? src[i] + 1 : 2 * src[i] + 2;
            if (src[i] >= 0)
                check({what, " toggles"}, e, tog[i]);
        end
        check({what, " complement"}, ~pins_p & pins_oe, pins_n & pins_oe);
        if (src[0] >= 0)
            check({what, " captures"}, src[0] + 1, captures - c0);
        $display("test %s done", what);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic ref_mode(input logic [3:0] mode);
        logic prev_a;
        int lag;
        lag = 0;
        cfg(SRC_REF, 1'b1, mode);
        @(negedge link_clk);
        prev_a = rx_if_clk_a_p;
        for (int k = 0; k < 32; k++)
        begin
            @(posedge link_clk);
            if (k % 4 == 0)
                reference_clock <= ~reference_clock;
            @(negedge link_clk);
            lag += int'(rx_if_clk_c_p !== prev_a);
            prev_a = rx_if_clk_a_p;
        end
        repeat (6) @(negedge link_clk);
        check("ref enables", 4'h5, pins_oe);
        check("ref a toggles", 8, tog[0]);
        check("ref c toggles", 8, tog[2]);
        check("ref c lags a", 0, lag);
        for (int s = 0; s < 4 && (mode == `RXC_MODE_QUAD6 || mode == `RXC_MODE_QUAD8); s++)
        begin
            sel_drive <= s[1:0];
            repeat (8) @(posedge link_clk);
            check("master select", s, bond_master_sel);
            apb(1'b0, `RXC_STAT_OFF, 32'h0);
            check("status pins", 32'h4 | s, rd);
        end
        $display("test reference mode %0d done", mode);
    endtask

    initial
    begin
        repeat (8) @(posedge link_clk);
        check("reset enables", 4'h0, pins_oe);
        check("reset complements", 4'hF, pins_n);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, `RXC_CTRL_OFF, 32'h0);
        check("ctrl reset", 32'h1, rd);
        repeat (8) @(posedge link_clk);
        apb(1'b0, `RXC_STAT_OFF, 32'h0);
        check("stat reset", 32'h8, rd);
        apb(1'b1, 12'h010, 32'h7F);
        check("unmapped write error", 1, err);
        apb(1'b1, `RXC_STAT_OFF, 32'h1F);
        check("stat write error", 0, err);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped read", 32'h1, {rd[30:0], err});
        apb(1'b0, `RXC_CTRL_OFF, 32'h0);
        check("ctrl kept", 32'h1, rd);
        $display("test bus access done");
        // decoder bypass would need this same recovered setting
        cfg(SRC_RECOV, 1'b0, `RXC_MODE_INDEP0);
        run("recovered char rate", '{0, 1, 2, 3});
        cfg(SRC_RECOV, 1'b1, `RXC_MODE_INDEP2);
        run("recovered half rate", '{0, 1, 2, 3});
        cfg(2'h3, 1'b0, `RXC_MODE_INDEP0);
        run("disabled", '{-1, -1, -1, -1});
        cfg(SRC_BOND, 1'b0, 4'h1);
        run("bonded fallback", '{0, 1, 2, 3});
        ref_mode(`RXC_MODE_INDEP0);
        ref_mode(`RXC_MODE_QUAD6);
        ref_mode(`RXC_MODE_QUAD8);
        for (int m = 0; m < 6; m++)
            for (int s = 0; s < 4; s++)
            begin
                sel_drive <= s[1:0];
                cfg(SRC_BOND, m % 2 == 1, m < 2 ? 4'h3 + 4'(2 * m) : (m < 4 ? 4'h6 + 4'(2 * m - 4) : 4'(2 * m - 8)));
                if (m < 2)
                    run("bonded dual", '{s % 2, -1, 2 + s / 2, -1});
                else
                    run("bonded quad", '{s, -1, s, -1});
            end
        conclude();
    end
endmodule
